// ---- nve_params.svh ----
`ifndef NVE_PARAMS_SVH
`define NVE_PARAMS_SVH

// Direct function register addresses
`define NVE_A_INDIRECT_PORT   8'h02
`define NVE_A_INDIRECT_PTR    8'h03
`define NVE_A_BANK_SELECT     8'h04
`define NVE_A_IRQ_CTRL        8'h0E
`define NVE_A_CELL_INDEX      8'h1A
`define NVE_A_CELL_VALUE      8'h1B

// Control register location
`define NVE_CTRL_PTR          8'h40
`define NVE_CTRL_BANK         1'h1

// Control register fields
`define NVE_B_FETCH_TRIG      0
`define NVE_B_FETCH_PERMIT    1
`define NVE_B_PROG_TRIG       2
`define NVE_B_PROG_PERMIT     3
`define NVE_CTRL_RESET        4'h0

// Interrupt control fields
`define NVE_B_IRQ_GATE        0
`define NVE_B_IRQ_MASK        1
`define NVE_B_IRQ_FLAG        2

// Array size
`define NVE_CELLS             32
`define NVE_CELL_AW           5

// Timing
`define NVE_CLK_HZ            250000000
`define NVE_CLK_NS            4
`define NVE_LIRC_HZ           32000
`define NVE_READ_NS           12
`define NVE_READ_CYC  ((`NVE_READ_NS + `NVE_CLK_NS - 1) / `NVE_CLK_NS)
`define NVE_LIRC_DIV          (`NVE_CLK_HZ / `NVE_LIRC_HZ)
`define NVE_WRITE_TICKS       64

`endif

// ---- nve_pkg.sv ----
package nve_pkg;
	typedef logic [7:0] nve_byte_t;
	typedef logic [4:0] nve_cell_t;
	typedef enum logic [4:0] {
		H_IDLE,
		H_IDX,
		H_VAL,
		H_PTR,
		H_BANK,
		H_GATE_OFF,
		H_WPERMIT,
		H_WTRIG,
		H_GATE_ON,
		H_RPERMIT,
		H_RTRIG,
		H_POLL,
		H_POLL_WAIT,
		H_POLL_CHK,
		H_CLR_CTRL,
		H_CLR_BANK,
		H_FETCH,
		H_FETCH_WAIT,
		H_FETCH_TAKE,
		H_HALT
	} nve_host_state_e;
endpackage

// ---- nve_sfr_if.sv ----
interface nve_sfr_if;
	nve_pkg::nve_byte_t sfr_addr;
	logic               sfr_wr;
	nve_pkg::nve_byte_t sfr_wdata;
	nve_pkg::nve_byte_t sfr_rdata;
	logic               halt;
	logic               nv_irq_req;

	modport dev (
		input  sfr_addr,
		input  sfr_wr,
		input  sfr_wdata,
		input  halt,
		output sfr_rdata,
		output nv_irq_req
	);

	modport cpu (
		output sfr_addr,
		output sfr_wr,
		output sfr_wdata,
		output halt,
		input  sfr_rdata,
		input  nv_irq_req
	);
endinterface

// ---- nve_dev_end.sv ----
`include "nve_params.svh"

module nve_dev_end #(
	parameter int LIRC_DIV    = `NVE_LIRC_DIV,
	parameter int WRITE_TICKS = `NVE_WRITE_TICKS
) (
	input  wire logic  CLK_I,
	input  wire logic  RESET_I,
	nve_sfr_if.dev     SFR,
	output logic       WRITE_DONE_O
);
	localparam int PW = $clog2(LIRC_DIV);

	////////////////////////////////////////////////////////////////////////
	// Function registers

	nve_pkg::nve_byte_t mem [`NVE_CELLS];
	nve_pkg::nve_cell_t cell_index_reg;
	nve_pkg::nve_byte_t cell_value_reg;
	nve_pkg::nve_byte_t indirect_pointer_b_reg;
	logic               bank_select_reg;
	logic               program_permit_reg;
	logic               program_trig_reg;
	logic               fetch_permit_reg;
	logic               fetch_trig_reg;
	logic               global_irq_gate_reg;
	logic               nv_irq_mask_reg;
	logic               nv_irq_flag_reg;
	logic [3:0]         rd_cnt_reg;
	logic [PW-1:0]      presc_reg;
	logic [7:0]         wr_cnt_reg;
	nve_pkg::nve_byte_t rdata_reg;
	logic               irq_reg;
	logic               done_reg;

	logic ctrl_sel;
	logic ctrl_wr;
	logic start_rd;
	logic start_wr;
	logic rd_done;
	logic wr_done;
	logic tick;
	logic busy;

	assign ctrl_sel = bank_select_reg == `NVE_CTRL_BANK &&
		indirect_pointer_b_reg == `NVE_CTRL_PTR;
	assign ctrl_wr  = SFR.sfr_wr && SFR.sfr_addr == `NVE_A_INDIRECT_PORT &&
		ctrl_sel;
	assign busy     = fetch_trig_reg || program_trig_reg;
	assign start_rd = ctrl_wr && SFR.sfr_wdata[`NVE_B_FETCH_TRIG] &&
		!SFR.sfr_wdata[`NVE_B_PROG_TRIG] && fetch_permit_reg &&
		!busy && !SFR.halt;
	assign start_wr = ctrl_wr && SFR.sfr_wdata[`NVE_B_PROG_TRIG] &&
		!SFR.sfr_wdata[`NVE_B_FETCH_TRIG] && program_permit_reg &&
		!busy && !SFR.halt;
	assign tick     = presc_reg == PW'(LIRC_DIV - 1);
	assign rd_done  = fetch_trig_reg && rd_cnt_reg == 4'h0 && !SFR.halt;
	assign wr_done  = program_trig_reg && wr_cnt_reg == 8'h00 &&
		!SFR.halt;

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			cell_index_reg         <= 5'h00;
			indirect_pointer_b_reg <= 8'h00;
			bank_select_reg        <= 1'h0;
		end else if (SFR.sfr_wr) begin
			if (SFR.sfr_addr == `NVE_A_CELL_INDEX)
				cell_index_reg <= SFR.sfr_wdata[`NVE_CELL_AW-1:0];
			if (SFR.sfr_addr == `NVE_A_INDIRECT_PTR)
				indirect_pointer_b_reg <= SFR.sfr_wdata;
			if (SFR.sfr_addr == `NVE_A_BANK_SELECT)
				bank_select_reg <= SFR.sfr_wdata[0];
		end
	end

	// Permit bits follow software; zero written clears them
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			program_permit_reg <= 1'h0;
			fetch_permit_reg   <= 1'h0;
		end else if (ctrl_wr) begin
			program_permit_reg <= SFR.sfr_wdata[`NVE_B_PROG_PERMIT];
			fetch_permit_reg   <= SFR.sfr_wdata[`NVE_B_FETCH_PERMIT];
		end
	end

	// Triggers stay high for the cycle and drop by hardware
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			fetch_trig_reg   <= 1'h0;
			program_trig_reg <= 1'h0;
		end else if (SFR.halt) begin
			fetch_trig_reg   <= 1'h0;
			program_trig_reg <= 1'h0;
		end else begin
			if (rd_done)
				fetch_trig_reg <= 1'h0;
			else if (start_rd)
				fetch_trig_reg <= 1'h1;
			if (wr_done)
				program_trig_reg <= 1'h0;
			else if (start_wr)
				program_trig_reg <= 1'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Cycle timing

	always_ff @(posedge CLK_I) begin
		if (RESET_I)
			rd_cnt_reg <= 4'h0;
		else if (start_rd)
			rd_cnt_reg <= 4'(`NVE_READ_CYC - 1);
		else if (rd_cnt_reg != 4'h0)
			rd_cnt_reg <= rd_cnt_reg - 4'h1;
	end

	// Free-running low-speed timer, not in step with the write launch
	always_ff @(posedge CLK_I) begin
		if (RESET_I)
			presc_reg <= '0;
		else if (tick)
			presc_reg <= '0;
		else
			presc_reg <= presc_reg + PW'(1);
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I)
			wr_cnt_reg <= 8'h00;
		else if (start_wr)
			wr_cnt_reg <= 8'(WRITE_TICKS);
		else if (tick && wr_cnt_reg != 8'h00)
			wr_cnt_reg <= wr_cnt_reg - 8'h01;
	end

	////////////////////////////////////////////////////////////////////////
	// Array and value register

	always_ff @(posedge CLK_I) begin
		if (wr_done)
			mem[cell_index_reg] <= cell_value_reg;
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I)
			cell_value_reg <= 8'h00;
		else if (rd_done)
			cell_value_reg <= mem[cell_index_reg];
		else if (SFR.sfr_wr && SFR.sfr_addr == `NVE_A_CELL_VALUE)
			cell_value_reg <= SFR.sfr_wdata;
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt request

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			global_irq_gate_reg <= 1'h0;
			nv_irq_mask_reg     <= 1'h0;
			nv_irq_flag_reg     <= 1'h0;
		end else begin
			if (SFR.sfr_wr && SFR.sfr_addr == `NVE_A_IRQ_CTRL) begin
				global_irq_gate_reg <= SFR.sfr_wdata[`NVE_B_IRQ_GATE];
				nv_irq_mask_reg     <= SFR.sfr_wdata[`NVE_B_IRQ_MASK];
				nv_irq_flag_reg     <= SFR.sfr_wdata[`NVE_B_IRQ_FLAG];
			end
			if (wr_done)
				nv_irq_flag_reg <= 1'h1;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			irq_reg  <= 1'h0;
			done_reg <= 1'h0;
		end else begin
			irq_reg  <= nv_irq_flag_reg && nv_irq_mask_reg &&
				global_irq_gate_reg;
			done_reg <= wr_done;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read-back

	always_ff @(posedge CLK_I) begin
		if (RESET_I)
			rdata_reg <= 8'h00;
		else begin
			case (SFR.sfr_addr)
				`NVE_A_CELL_INDEX:   rdata_reg <= {3'h0, cell_index_reg};
				`NVE_A_CELL_VALUE:   rdata_reg <= cell_value_reg;
				`NVE_A_INDIRECT_PTR: rdata_reg <= indirect_pointer_b_reg;
				`NVE_A_BANK_SELECT:  rdata_reg <= {7'h00, bank_select_reg};
				`NVE_A_IRQ_CTRL:     rdata_reg <= {5'h00, nv_irq_flag_reg,
					nv_irq_mask_reg, global_irq_gate_reg};
				`NVE_A_INDIRECT_PORT: begin
					if (ctrl_sel)
						rdata_reg <= {4'h0, program_permit_reg,
							program_trig_reg, fetch_permit_reg, fetch_trig_reg};
					else
						rdata_reg <= 8'h00;
				end
				default:             rdata_reg <= 8'h00;
			endcase
		end
	end

	assign SFR.sfr_rdata  = rdata_reg;
	assign SFR.nv_irq_req = irq_reg;
	assign WRITE_DONE_O   = done_reg;
endmodule

// ---- nve_cpu_end.sv ----
`include "nve_params.svh"

module nve_cpu_end (
	input  wire logic                CLK_I,
	input  wire logic                RESET_I,
	nve_sfr_if.cpu                   SFR,
	input  wire logic                CMD_VALID_I,
	input  wire logic                CMD_WRITE_I,
	input  wire nve_pkg::nve_cell_t  CMD_ADDR_I,
	input  wire nve_pkg::nve_byte_t  CMD_DATA_I,
	input  wire logic                SLEEP_REQ_I,
	output logic                     CMD_READY_O,
	output logic                     RSP_VALID_O,
	output nve_pkg::nve_byte_t       RSP_DATA_O
);
	nve_pkg::nve_host_state_e state_reg;
	nve_pkg::nve_cell_t       addr_hold_reg;
	nve_pkg::nve_byte_t       data_hold_reg;
	logic                     is_write_reg;
	nve_pkg::nve_byte_t       bus_addr_reg;
	logic                     bus_wr_reg;
	nve_pkg::nve_byte_t       bus_wdata_reg;
	logic                     halt_reg;
	logic                     ready_reg;
	logic                     rsp_valid_reg;
	nve_pkg::nve_byte_t       rsp_data_reg;

	////////////////////////////////////////////////////////////////////////
	// Sequencer: one register access per step

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			state_reg     <= nve_pkg::H_IDLE;
			addr_hold_reg <= 5'h00;
			data_hold_reg <= 8'h00;
			is_write_reg  <= 1'h0;
			bus_addr_reg  <= 8'h00;
			bus_wr_reg    <= 1'h0;
			bus_wdata_reg <= 8'h00;
			halt_reg      <= 1'h0;
			ready_reg     <= 1'h0;
			rsp_valid_reg <= 1'h0;
			rsp_data_reg  <= 8'h00;
		end else begin
			bus_wr_reg    <= 1'h0;
			rsp_valid_reg <= 1'h0;
			ready_reg     <= 1'h0;
			case (state_reg)
				nve_pkg::H_IDLE: begin
					if (SLEEP_REQ_I) begin
						halt_reg  <= 1'h1;
						state_reg <= nve_pkg::H_HALT;
					end else if (CMD_VALID_I && ready_reg) begin
						addr_hold_reg <= CMD_ADDR_I;
						data_hold_reg <= CMD_DATA_I;
						is_write_reg  <= CMD_WRITE_I;
						state_reg     <= nve_pkg::H_IDX;
					end else
						ready_reg <= 1'h1;
				end
				nve_pkg::H_HALT: begin
					if (!SLEEP_REQ_I) begin
						halt_reg  <= 1'h0;
						state_reg <= nve_pkg::H_IDLE;
					end
				end
				nve_pkg::H_IDX: begin
					bus_wr_reg    <= 1'h1;
					bus_addr_reg  <= `NVE_A_CELL_INDEX;
					bus_wdata_reg <= {3'h0, addr_hold_reg};
					state_reg     <= is_write_reg ? nve_pkg::H_VAL :
						nve_pkg::H_PTR;
				end
				nve_pkg::H_VAL: begin
					bus_wr_reg    <= 1'h1;
					bus_addr_reg  <= `NVE_A_CELL_VALUE;
					bus_wdata_reg <= data_hold_reg;
					state_reg     <= nve_pkg::H_PTR;
				end
				nve_pkg::H_PTR: begin
					bus_wr_reg    <= 1'h1;
					bus_addr_reg  <= `NVE_A_INDIRECT_PTR;
					bus_wdata_reg <= `NVE_CTRL_PTR;
					state_reg     <= nve_pkg::H_BANK;
				end
				nve_pkg::H_BANK: begin
					bus_wr_reg    <= 1'h1;
					bus_addr_reg  <= `NVE_A_BANK_SELECT;
					bus_wdata_reg <= {7'h00, `NVE_CTRL_BANK};
					state_reg     <= is_write_reg ? nve_pkg::H_GATE_OFF :
						nve_pkg::H_RPERMIT;
				end
				nve_pkg::H_GATE_OFF: begin
					bus_wr_reg    <= 1'h1;
					bus_addr_reg  <= `NVE_A_IRQ_CTRL;
					bus_wdata_reg <= 8'h00;
					state_reg     <= nve_pkg::H_WPERMIT;
				end
				nve_pkg::H_WPERMIT: begin
					bus_wr_reg    <= 1'h1;
					bus_addr_reg  <= `NVE_A_INDIRECT_PORT;
					bus_wdata_reg <= 8'h08;
					state_reg     <= nve_pkg::H_WTRIG;
				end
				nve_pkg::H_WTRIG: begin
					bus_wr_reg    <= 1'h1;
					bus_addr_reg  <= `NVE_A_INDIRECT_PORT;
					bus_wdata_reg <= 8'h0C;
					state_reg     <= nve_pkg::H_GATE_ON;
				end
				nve_pkg::H_GATE_ON: begin
					bus_wr_reg    <= 1'h1;
					bus_addr_reg  <= `NVE_A_IRQ_CTRL;
					bus_wdata_reg <= 8'h01;
					state_reg     <= nve_pkg::H_POLL;
				end
				nve_pkg::H_RPERMIT: begin
					bus_wr_reg    <= 1'h1;
					bus_addr_reg  <= `NVE_A_INDIRECT_PORT;
					bus_wdata_reg <= 8'h02;
					state_reg     <= nve_pkg::H_RTRIG;
				end
				nve_pkg::H_RTRIG: begin
					bus_wr_reg    <= 1'h1;
					bus_addr_reg  <= `NVE_A_INDIRECT_PORT;
					bus_wdata_reg <= 8'h03;
					state_reg     <= nve_pkg::H_POLL;
				end
				nve_pkg::H_POLL: begin
					bus_addr_reg <= `NVE_A_INDIRECT_PORT;
					state_reg    <= nve_pkg::H_POLL_WAIT;
				end
				nve_pkg::H_POLL_WAIT: state_reg <= nve_pkg::H_POLL_CHK;
				nve_pkg::H_POLL_CHK: begin
					if (!SFR.sfr_rdata[`NVE_B_PROG_TRIG] &&
						!SFR.sfr_rdata[`NVE_B_FETCH_TRIG])
						state_reg <= nve_pkg::H_CLR_CTRL;
				end
				nve_pkg::H_CLR_CTRL: begin
					bus_wr_reg    <= 1'h1;
					bus_addr_reg  <= `NVE_A_INDIRECT_PORT;
					bus_wdata_reg <= 8'h00;
					state_reg     <= nve_pkg::H_CLR_BANK;
				end
				nve_pkg::H_CLR_BANK: begin
					bus_wr_reg    <= 1'h1;
					bus_addr_reg  <= `NVE_A_BANK_SELECT;
					bus_wdata_reg <= 8'h00;
					state_reg     <= is_write_reg ? nve_pkg::H_IDLE :
						nve_pkg::H_FETCH;
					if (is_write_reg) begin
						bus_addr_reg  <= `NVE_A_IRQ_CTRL;
						bus_wdata_reg <= 8'h01;
					end
				end
				nve_pkg::H_FETCH: begin
					bus_addr_reg <= `NVE_A_CELL_VALUE;
					state_reg    <= nve_pkg::H_FETCH_WAIT;
				end
				nve_pkg::H_FETCH_WAIT: state_reg <= nve_pkg::H_FETCH_TAKE;
				nve_pkg::H_FETCH_TAKE: begin
					rsp_valid_reg <= 1'h1;
					rsp_data_reg  <= SFR.sfr_rdata;
					state_reg     <= nve_pkg::H_IDLE;
				end
				default: state_reg <= nve_pkg::H_IDLE;
			endcase
		end
	end

	assign SFR.sfr_addr  = bus_addr_reg;
	assign SFR.sfr_wr    = bus_wr_reg;
	assign SFR.sfr_wdata = bus_wdata_reg;
	assign SFR.halt      = halt_reg;
	assign CMD_READY_O   = ready_reg;
	assign RSP_VALID_O   = rsp_valid_reg;
	assign RSP_DATA_O    = rsp_data_reg;
endmodule

// ---- nve_props.sv ----
module nve_props (
	input wire logic               CLK_I,
	input wire logic               RESET_I,
	input wire nve_pkg::nve_byte_t sfr_addr,
	input wire logic               sfr_wr,
	input wire nve_pkg::nve_byte_t sfr_wdata,
	input wire nve_pkg::nve_byte_t sfr_rdata,
	input wire logic               halt,
	input wire logic               nv_irq_req,
	input wire logic               WRITE_DONE_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);

	logic               w_port;
	nve_pkg::nve_byte_t ptr_reg;
	logic               bank_reg;

	assign w_port = sfr_wr && sfr_addr == 8'h02;

	// Shadow of the pointer and bank the port access depends on
	always_ff @(posedge CLK_I) begin
		if (RESET_I)
			ptr_reg <= 8'h00;
		else if (sfr_wr && sfr_addr == 8'h03)
			ptr_reg <= sfr_wdata;
	end
	always_ff @(posedge CLK_I) begin
		if (RESET_I)
			bank_reg <= 1'b0;
		else if (sfr_wr && sfr_addr == 8'h04)
			bank_reg <= sfr_wdata[0];
	end

	////////////////////////////////////////////////////////////////////////
	property p_trig_next;
		w_port && sfr_wdata == 8'h08 |=> w_port && sfr_wdata == 8'h0C;
	endproperty
	a_trig_next: assert property (p_trig_next) else $error("trigger late");
	property p_gate;
		w_port && sfr_wdata == 8'h0C
		|-> $past(sfr_wr && sfr_addr == 8'h0E && !sfr_wdata[0], 2)
		##1 (sfr_wr && sfr_addr == 8'h0E && sfr_wdata[0]);
	endproperty
	a_gate: assert property (p_gate) else $error("gate order bad");
	property p_read_seq;
		w_port && sfr_wdata == 8'h03
		|-> $past(w_port && sfr_wdata == 8'h02)
		&& $past(sfr_wr && sfr_addr == 8'h1A, 4);
	endproperty
	a_read_seq: assert property (p_read_seq) else $error("read order bad");
	property p_write_seq;
		w_port && sfr_wdata == 8'h08 |-> $past(sfr_wr && sfr_addr == 8'h1B, 4);
	endproperty
	a_write_seq: assert property (p_write_seq) else $error("write order");
	property p_write_time;
		w_port && sfr_wdata == 8'h0C
		|=> (!WRITE_DONE_O) [*8] ##[1:6] WRITE_DONE_O;
	endproperty
	a_write_time: assert property (p_write_time) else $error("write time");
	property p_ctrl_loc;
		w_port |-> ptr_reg == 8'h40 && bank_reg;
	endproperty
	a_ctrl_loc: assert property (p_ctrl_loc) else $error("port misused");
	property p_bank_clear;
		w_port && sfr_wdata == 8'h03 |-> ##[2:60] (sfr_wr && sfr_addr == 8'h04
		&& sfr_wdata == 8'h00 && $past(w_port && sfr_wdata == 8'h00));
	endproperty
	a_bank_clear: assert property (p_bank_clear) else $error("no clear");
	property p_halt_quiet;
		halt |-> !sfr_wr;
	endproperty
	a_halt_quiet: assert property (p_halt_quiet) else $error("write in halt");
	property p_reset_state;
		$fell(RESET_I) |-> !sfr_wr && !halt && !nv_irq_req;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("reset");
	property p_index_width;
		sfr_wr && sfr_addr == 8'h1A |-> sfr_wdata[7:5] == 3'h0;
	endproperty
	a_index_width: assert property (p_index_width) else $error("index");
	property p_permit_off;
		w_port && sfr_wdata == 8'h0C
		|-> ##[4:40] (w_port && sfr_wdata == 8'h00);
	endproperty
	a_permit_off: assert property (p_permit_off) else $error("permit on");
endmodule

// ---- data_eeprom_access_ctrl_tb_top.sv ----
module data_eeprom_access_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic               clk;
	logic               rst;
	logic               cmd_valid;
	logic               cmd_write;
	logic               sleep_req;
	logic               cmd_ready;
	logic               rsp_valid;
	logic               done_a;
	logic               done_b;
	nve_pkg::nve_cell_t cmd_addr;
	nve_pkg::nve_byte_t cmd_data;
	nve_pkg::nve_byte_t rsp_data;
	nve_pkg::nve_byte_t shadow [32];
	nve_pkg::nve_byte_t got;
	nve_pkg::nve_byte_t val;
	logic [31:0]        r;
	int                 fail_count;
	int                 comparisons;
	int                 seed;
	int                 done_a_count = 0;
	int                 done_b_count = 0;
	int                 write_count = 0;

	nve_sfr_if bus_a ();
	nve_sfr_if bus_b ();
	nve_dev_end #(.LIRC_DIV(4), .WRITE_TICKS(3)) nve_dev_end_inst (
		.CLK_I(clk), .RESET_I(rst), .SFR(bus_a.dev), .WRITE_DONE_O(done_a));
	// Second device is driven straight from the bench to break the rules
	nve_dev_end #(.LIRC_DIV(4), .WRITE_TICKS(3)) nve_dev_end_inst_b (
		.CLK_I(clk), .RESET_I(rst), .SFR(bus_b.dev), .WRITE_DONE_O(done_b));
	nve_cpu_end nve_cpu_end_inst (
		.CLK_I(clk), .RESET_I(rst), .SFR(bus_a.cpu), .CMD_VALID_I(cmd_valid),
		.CMD_WRITE_I(cmd_write), .CMD_ADDR_I(cmd_addr), .CMD_DATA_I(cmd_data),
		.SLEEP_REQ_I(sleep_req), .CMD_READY_O(cmd_ready),
		.RSP_VALID_O(rsp_valid), .RSP_DATA_O(rsp_data));
	nve_props nve_props_inst (
		.CLK_I(clk), .RESET_I(rst), .sfr_addr(bus_a.sfr_addr),
		.sfr_wr(bus_a.sfr_wr), .sfr_wdata(bus_a.sfr_wdata),
		.sfr_rdata(bus_a.sfr_rdata), .halt(bus_a.halt),
		.nv_irq_req(bus_a.nv_irq_req), .WRITE_DONE_O(done_a));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// One-cycle done pulses are counted mid-cycle, where they stand
	always @(negedge clk) begin
		if (done_a === 1'b1)
			done_a_count <= done_a_count + 1;
		if (done_b === 1'b1)
			done_b_count <= done_b_count + 1;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic stall();
		fail_count++;
		$display("wrong value at %0t: wait ran out", $time);
		give_verdict();
	endtask
	task automatic chk(input nve_pkg::nve_byte_t seen,
	                   input nve_pkg::nve_byte_t exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h want %h", $time, seen, exp);
		end
	endtask
	function automatic nve_pkg::nve_byte_t exp_read(nve_pkg::nve_cell_t a);
		return shadow[a];
	endfunction
	task automatic bw(input nve_pkg::nve_byte_t a, input nve_pkg::nve_byte_t d);
		@(negedge clk);
		bus_b.sfr_addr = a;
		bus_b.sfr_wdata = d;
		bus_b.sfr_wr = 1'b1;
		@(negedge clk);
		bus_b.sfr_wr = 1'b0;
		bus_b.sfr_wdata = ~d;
	endtask
	task automatic br(input nve_pkg::nve_byte_t a);
		@(negedge clk);
		bus_b.sfr_addr = a;
		@(negedge clk);
		got = bus_b.sfr_rdata;
	endtask
	task automatic poll_b(input nve_pkg::nve_byte_t m);
		for (int n = 0; n < 100; n++) begin
			br(8'h02);
			if ((got & m) === 8'h00)
				return;
		end
		stall();
	endtask
	task automatic cmd(input logic w, input nve_pkg::nve_cell_t a,
	                   input nve_pkg::nve_byte_t d);
		int n = 0;
		@(negedge clk);
		while (cmd_ready !== 1'b1) begin
			if (++n > 300)
				stall();
			@(negedge clk);
		end
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_addr = a;
		cmd_data = d;
		@(negedge clk);
		cmd_valid = 1'b0;
		if (w) begin
			shadow[a] = d;
			write_count++;
			return;
		end
		while (rsp_valid !== 1'b1) begin
			if (++n > 300)
				stall();
			@(negedge clk);
		end
		chk(rsp_data, exp_read(a));
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 78477;
		fail_count = 0;
		comparisons = 0;
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_addr = 5'h00;
		cmd_data = 8'h00;
		sleep_req = 1'b0;
		bus_b.sfr_addr = 8'h00;
		bus_b.sfr_wr = 1'b0;
		bus_b.sfr_wdata = 8'h00;
		bus_b.halt = 1'b0;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		// Refusals and cycle flags on the bench-driven device
		bw(8'h03, 8'h40);
		bw(8'h04, 8'h01);
		br(8'h02);
		chk(got, 8'h00);
		bw(8'h04, 8'h00);
		bw(8'h02, 8'h08);
		br(8'h02);
		chk(got, 8'h00);
		bw(8'h04, 8'h01);
		br(8'h02);
		chk(got, 8'h00);
		bw(8'h02, 8'h01);
		br(8'h02);
		chk(got, 8'h00);
		bw(8'h02, 8'h04);
		br(8'h02);
		chk(got, 8'h00);
		r = $random(seed);
		val = r[7:0];
		bw(8'h1A, 8'h1F);
		bw(8'h1B, val);
		bw(8'h02, 8'h08);
		bw(8'h02, 8'h0C);
		br(8'h02);
		chk(got, 8'h0C);
		poll_b(8'h04);
		chk(got, 8'h08);
		br(8'h0E);
		chk(got, 8'h04);
		bw(8'h0E, 8'h07);
		@(negedge clk);
		chk({7'h00, bus_b.nv_irq_req}, 8'h01);
		bw(8'h0E, 8'h00);
		bw(8'h1B, ~val);
		bw(8'h02, 8'h0A);
		bw(8'h02, 8'h0B);
		br(8'h02);
		chk(got, 8'h0B);
		poll_b(8'h01);
		chk(got, 8'h0A);
		br(8'h1B);
		chk(got, val);
		bw(8'h02, 8'h00);
		bw(8'h02, 8'h01);
		br(8'h02);
		chk(got, 8'h00);
		// Halt in mid-write drops the cycle and raises no flag
		bw(8'h1B, ~val);
		bw(8'h02, 8'h08);
		bw(8'h02, 8'h0C);
		bus_b.halt = 1'b1;
		@(negedge clk);
		bus_b.halt = 1'b0;
		repeat (16) @(negedge clk);
		br(8'h02);
		chk(got, 8'h08);
		br(8'h0E);
		chk(got, 8'h00);
		chk(8'(done_b_count), 8'h01);
		// Both ends together: fill the array, then mixed random traffic
		for (int i = 0; i < 32; i++) begin
			r = $random(seed);
			cmd(1'b1, 5'(i), (i == 0) ? 8'h00 : (i == 31) ? 8'hFF : r[7:0]);
		end
		cmd(1'b0, 5'h00, 8'h00);
		cmd(1'b0, 5'h1F, 8'h00);
		cmd(1'b0, 5'h01, 8'h00);
		for (int i = 0; i < 40; i++) begin
			r = $random(seed);
			cmd(r[8], r[4:0], r[23:16]);
		end
		@(negedge clk);
		// A write taken last may still run; sleep only from idle
		for (int n = 0; cmd_ready !== 1'b1; n++) begin
			if (n > 300)
				stall();
			@(negedge clk);
		end
		chk(8'(done_a_count), 8'(write_count));
		sleep_req = 1'b1;
		repeat (2) @(negedge clk);
		chk({7'h00, bus_a.halt}, 8'h01);
		sleep_req = 1'b0;
		cmd(1'b0, 5'h1F, 8'h00);
		give_verdict();
	end
endmodule
